// File: core/acs_conv_seq.sv
// Conversion sequencer: scan control, result FIFO and serial port of a 12-bit converter.
`include "acs_defs.svh"
module acs_conv_seq #(
   parameter int WAKE_CYC = 20,  // Converter wake-up time in cycles.
   parameter int CONV_CYC = 16   // One conversion in cycles.
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic convert_start_n,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic din,
   output logic dout,
   output logic eoc_n,
   input wire logic mode_load,
   input wire logic [1:0] mode_in,
   output logic [1:0] mode,
   input wire acs_pkg::acs_cfg_s cfg,
   input wire logic [11:0] adc_data,
   input wire logic [11:0] temp_data,
   output logic adc_on,
   output logic [3:0] mux_sel,
   output logic temp_sel,
   output logic [7:0] wr_byte,
   output logic wr_stb,
   output logic [4:0] fifo_level
);
   // ----------------------------------------------------------------
   // Pin edges and derived values
   // ----------------------------------------------------------------
   acs_pkg::acs_reg_s q;  // Registered state.
   acs_pkg::acs_reg_s n;  // Next state.
   logic cv_fall, cv_rise, cs_fall, cs_rise, sk_rise, sk_fall, cs_lo;
   assign cv_fall = q.s3[3] & ~q.s2[3];
   assign cv_rise = ~q.s3[3] & q.s2[3];
   assign cs_fall = q.s3[2] & ~q.s2[2];
   assign cs_rise = ~q.s3[2] & q.s2[2];
   assign sk_rise = ~q.s3[1] & q.s2[1];
   assign sk_fall = q.s3[1] & ~q.s2[1];
   assign cs_lo = ~q.s2[2];
   logic [5:0] navg;      // Conversions per result.
   logic [2:0] sh;        // Averaging divide shift.
   logic [11:0] sample;   // Converter output for this conversion.
   logic [16:0] acc_nx;   // Accumulator including this conversion.
   logic [15:0] head;     // FIFO head as shifted out.
   logic [7:0] m11_c;     // Falling edge count after this edge.
   logic [7:0] m11_base;  // Edge count where the result window opens.
   logic [7:0] m11_p;     // Position inside the result window.
   assign navg = cfg.avg_on ? (6'h4 << cfg.avg_sel) : 6'h1;
   assign sh = cfg.avg_on ? 3'({1'b0, cfg.avg_sel} + 3'h2) : 3'h0;
   assign sample = q.in_temp ? temp_data : adc_data;
   assign acc_nx = q.acc + {5'h0, sample};
   // An empty FIFO shows zeros, not a stale slot left behind by an earlier pop.
   assign head = (q.cnt_f == 5'h0) ? 16'h0 : {4'h0, q.mem[q.rp]};
   assign m11_c = q.m11_n + 8'h1;
   assign m11_base = cfg.temp_req ? `ACS_SCK_TEMP_BASE : 8'h0;
   assign m11_p = m11_c - m11_base;
   logic conv_wr, push, pop, finish, ch_push, conv_done, scan_mode;
   logic [11:0] push_val;
   logic [4:0] nidx;
   assign conv_done = (q.st == acs_pkg::st_conv) && (q.cnt == 10'h0);
   assign scan_mode = (q.mode == `ACS_MODE_CNV_SCAN) || (q.mode == `ACS_MODE_SER_SCAN);

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   // Fills the next state from pins, configuration and current state.
   always_comb begin
      n = q;
      conv_wr = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      finish = 1'b0;
      ch_push = 1'b0;
      push_val = 12'h0;
      nidx = q.idx;
      n.s1 = {convert_start_n, cs_n, sclk, din};
      n.s2 = q.s1;
      n.s3 = q.s2;
      n.wr_stb = 1'b0;
      if (mode_load) begin
         n.mode = mode_in;
      end
      // Receive: bits are taken on rising serial clock edges.
      if (cs_lo && sk_rise) begin
         n.rx = {q.rx[6:0], q.s2[0]};
         n.rxn = q.rxn + 4'h1;
         if (q.rxn == 4'h7) begin
            n.wr_byte = {q.rx[6:0], q.s2[0]};
            n.wr_stb = 1'b1;
            n.rxn = 4'h0;
            conv_wr = q.rx[6];
         end
      end
      // A cut byte replaces only the bits received, from the MSB down.
      if (cs_rise && (q.rxn != 4'h0)) begin
         n.wr_byte = 8'(q.rx << (4'h8 - q.rxn)) | (q.wr_byte & (8'hff >> q.rxn));
         n.wr_stb = 1'b1;
         n.rxn = 4'h0;
      end
      // Transmit the FIFO head; the first bit stands from chip select fall.
      if (cs_fall && !q.m11) begin
         n.dout = head[4'hf - q.idx[3:0]];
      end
      // The read position only moves while an entry is present, so bytes clocked against an empty FIFO
      // (a conversion byte, for one) leave no half-read entry behind.
      if (cs_lo && sk_fall && !q.m11 && (q.cnt_f != 5'h0)) begin
         nidx = q.idx + 5'h1;
         if (nidx == q.lim) begin
            nidx = 5'h0;
            n.lim = `ACS_WORD_BITS;
            pop = (q.cnt_f != 5'h0);
            n.dout = 1'b0;
         end else begin
            n.dout = head[4'hf - nidx[3:0]];
         end
         n.idx = nidx;
      end
      // Chip select rising mid-byte shortens or drops that entry.
      if (cs_rise && !q.m11) begin
         if ((q.idx != 5'h0) && (q.idx < `ACS_BYTE_BITS)) begin
            n.lim = q.idx + `ACS_BYTE_BITS;
         end else if (q.idx > `ACS_BYTE_BITS) begin
            n.idx = 5'h0;
            n.lim = `ACS_WORD_BITS;
            pop = (q.cnt_f != 5'h0);
         end
      end
      // Serial-clocked conversion: the result window follows the byte.
      if (conv_wr && (q.mode == `ACS_MODE_SER_CLK)) begin
         n.m11 = 1'b1;
         n.m11_n = 8'hff;
         n.m11_word = cfg.temp_req ? temp_data : adc_data;
         n.adc_on = 1'b1;
      end else if (q.m11 && cs_lo && sk_fall) begin
         n.m11_n = m11_c;
         n.dout = (m11_c >= m11_base) && (m11_p < `ACS_SCK_WIN) ? n.m11_word[4'hf - m11_p[3:0]] : 1'b0;
         if (m11_p[3:0] < 4'h4) begin
            n.dout = 1'b0;
         end
         if (m11_p == `ACS_SCK_WIN - 8'h1) begin
            n.m11 = 1'b0;
            n.adc_on = 1'b0;
         end
      end
      // Scan sequencer.
      unique case (q.st)
         acs_pkg::st_idle: begin
            if (((q.mode == `ACS_MODE_CNV_SCAN) && cv_rise) ||
                ((q.mode == `ACS_MODE_SER_SCAN) && conv_wr)) begin
               n.st = acs_pkg::st_wake;
               n.cnt = cfg.ref_wake ? 10'(`ACS_REF_UP_CYC - 1) : 10'(WAKE_CYC - 1);
               n.adc_on = 1'b1;
               n.in_temp = cfg.temp_req;
               n.chan = cfg.chan_first;
               n.nconv = 6'h0;
               n.acc = 17'h0;
            end else if ((q.mode == `ACS_MODE_CNV_EXT) && cv_fall) begin
               n.st = acs_pkg::st_track;
               n.adc_on = 1'b1;
            end
            if ((q.mode == `ACS_MODE_CNV_EXT) && conv_wr) begin
               n.temp_pend = cfg.temp_req;
               n.chan = cfg.chan_first;
               n.nconv = 6'h0;
               n.acc = 17'h0;
            end
         end
         acs_pkg::st_track: begin
            if (cv_rise && q.temp_pend) begin
               n.st = acs_pkg::st_wake;
               n.cnt = 10'(`ACS_REF_UP_CYC - 1);
               n.in_temp = 1'b1;
               n.temp_pend = 1'b0;
            end else if (cv_rise) begin
               n.st = acs_pkg::st_conv;
               n.cnt = 10'(CONV_CYC - 1);
            end
         end
         acs_pkg::st_wake: begin
            n.cnt = q.cnt - 10'h1;
            if (q.cnt == 10'h0) begin
               n.st = acs_pkg::st_conv;
               n.cnt = 10'(CONV_CYC - 1);
            end
         end
         acs_pkg::st_conv: begin
            n.cnt = q.cnt - 10'h1;
            if (q.cnt == 10'h0) begin
               n.cnt = 10'(CONV_CYC - 1);
               if (q.in_temp) begin
                  push = 1'b1;
                  push_val = temp_data;
                  n.in_temp = 1'b0;
               end else if (q.nconv == navg - 6'h1) begin
                  push = 1'b1;
                  ch_push = 1'b1;
                  push_val = 12'(acc_nx >> sh);
                  n.acc = 17'h0;
                  n.nconv = 6'h0;
                  n.chan = (q.chan == cfg.chan_last) ? cfg.chan_first : q.chan + 4'h1;
                  finish = (q.chan == cfg.chan_last);
               end else begin
                  n.acc = acc_nx;
                  n.nconv = q.nconv + 6'h1;
               end
               if (finish || (q.mode == `ACS_MODE_CNV_EXT)) begin
                  n.st = acs_pkg::st_idle;
                  n.adc_on = 1'b0;
                  finish = 1'b1;
               end
            end
         end
      endcase
      // Chip select falling during a scan aborts it.
      if (cs_fall && scan_mode && (q.st != acs_pkg::st_idle)) begin
         n.st = acs_pkg::st_idle;
         n.adc_on = 1'b0;
         finish = 1'b0;
      end
      // End of conversion: the finish wins over a clear in the same cycle, unless a chip select fall aborts the scan.
      if (cs_fall || (cv_fall && (q.mode != `ACS_MODE_SER_SCAN))) begin
         n.eoc_n = 1'b1;
      end
      if (finish) begin
         n.eoc_n = 1'b0;
      end
      // FIFO bookkeeping; a push into a full FIFO is dropped unless an entry pops in the same cycle.
      if (push && ((q.cnt_f < `ACS_FIFO_DEPTH) || pop)) begin
         n.mem[q.wp] = push_val;
         n.wp = q.wp + 4'h1;
         n.cnt_f = q.cnt_f + 5'h1 - {4'h0, pop};
      end else begin
         n.cnt_f = q.cnt_f - {4'h0, pop};
      end
      n.rp = q.rp + {3'h0, pop};
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Registers the whole state; reset loads constants only.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
         // Synchronisers start at the idle pin levels (clock low) so no false edge follows reset.
         q.s1 <= 4'hd;
         q.s2 <= 4'hd;
         q.s3 <= 4'hd;
         q.st <= acs_pkg::st_idle;
         q.mode <= `ACS_MODE_RST;
         q.eoc_n <= 1'b1;
         q.lim <= `ACS_WORD_BITS;
      end else begin
         q <= n;
      end
   end

   assign dout = q.dout;
   assign eoc_n = q.eoc_n;
   assign mode = q.mode;
   assign adc_on = q.adc_on;
   assign mux_sel = q.chan;
   assign temp_sel = q.in_temp;
   assign wr_byte = q.wr_byte;
   assign wr_stb = q.wr_stb;
   assign fifo_level = q.cnt_f;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   sequence s_wake_started;
      (q.st == acs_pkg::st_wake) && q.adc_on;
   endsequence
   sequence s_idle_start(logic ev);
      (q.st == acs_pkg::st_idle) && ev;
   endsequence
   property p_mode_rst;
      $past(!rst_b) |-> (q.mode == `ACS_MODE_RST);
   endproperty
   a_mode_rst: assert property (p_mode_rst) else $error("mode after reset is not 10");
   property p_eoc_hold;
      (!q.eoc_n && !cs_fall && !cv_fall) |=> !q.eoc_n;
   endproperty
   a_eoc_hold: assert property (p_eoc_hold) else $error("eoc released without a pin fall");
   property p_m00_start;
      s_idle_start((q.mode == `ACS_MODE_CNV_SCAN) && cv_rise) |=> s_wake_started;
   endproperty
   a_m00_start: assert property (p_m00_start) else $error("convert rise did not start scan");
   property p_m10_start;
      s_idle_start((q.mode == `ACS_MODE_SER_SCAN) && conv_wr) |=> s_wake_started ##1 (q.st == acs_pkg::st_wake);
   endproperty
   a_m10_start: assert property (p_m10_start) else $error("conversion byte did not start scan");
   property p_m01_conv;
      ((q.st == acs_pkg::st_track) && cv_rise && !q.temp_pend) |=> (q.st == acs_pkg::st_conv) && q.adc_on;
   endproperty
   a_m01_conv: assert property (p_m01_conv) else $error("convert rise did not convert");
   property p_m01_temp;
      ((q.st == acs_pkg::st_track) && cv_rise && q.temp_pend) |=> s_wake_started ##0 q.in_temp ##0
         (q.cnt == 10'(`ACS_REF_UP_CYC - 1));
   endproperty
   a_m01_temp: assert property (p_m01_temp) else $error("temperature not timed internally");
   property p_m01_end;
      ((q.mode == `ACS_MODE_CNV_EXT) && conv_done) |=> !q.eoc_n && !q.adc_on && (q.st == acs_pkg::st_idle);
   endproperty
   a_m01_end: assert property (p_m01_end) else $error("conversion end did not shut down");
   property p_temp_first;
      ch_push |-> !q.in_temp;
   endproperty
   a_temp_first: assert property (p_temp_first) else $error("channel result before temperature");
   property p_avg_count;
      ch_push |-> (q.nconv == navg - 6'h1) ##1 (q.nconv == 6'h0);
   endproperty
   a_avg_count: assert property (p_avg_count) else $error("result written before averaging count");
   property p_no_scan_m11;
      q.m11 |-> (q.st == acs_pkg::st_idle);
   endproperty
   a_no_scan_m11: assert property (p_no_scan_m11) else $error("scan ran during serial-clocked mode");
   property p_part_rd;
      (cs_rise && !q.m11 && (q.idx != 5'h0) && (q.idx < 5'h8)) |=> (q.lim == $past(q.idx) + 5'h8);
   endproperty
   a_part_rd: assert property (p_part_rd) else $error("partial first byte not continued");
endmodule : acs_conv_seq

// File: core/acs_defs.svh
// Constants of the conversion sequencer: clock modes, timing counts and serial framing.
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH
// ----------------------------------------------------------------
// Clock modes and reset values
// ----------------------------------------------------------------
`define ACS_MODE_CNV_SCAN 2'h0
`define ACS_MODE_CNV_EXT 2'h1
`define ACS_MODE_SER_SCAN 2'h2
`define ACS_MODE_SER_CLK 2'h3
`define ACS_MODE_RST 2'h2
// ----------------------------------------------------------------
// Timing: system clock period and reference power-up wait
// ----------------------------------------------------------------
`define ACS_CLK_NS 100
`define ACS_REF_UP_NS 65000
`define ACS_REF_UP_CYC ((`ACS_REF_UP_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
// ----------------------------------------------------------------
// Serial framing of results
// ----------------------------------------------------------------
`define ACS_WORD_BITS 5'h10
`define ACS_BYTE_BITS 5'h08
`define ACS_SCK_TEMP_BASE 8'hb0
`define ACS_SCK_WIN 8'h10
`define ACS_FIFO_DEPTH 5'h10
`endif

// File: core/acs_pkg.sv
// Types of the conversion sequencer: states, configuration and the state record.
package acs_pkg;
   // ----------------------------------------------------------------
   // Sequencer states, one-hot.
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      st_idle = 4'h1,
      st_wake = 4'h2,
      st_track = 4'h4,
      st_conv = 4'h8
   } acs_state_e;

   // Static configuration presented by the register side.
   typedef struct packed {
      logic avg_on;            // Averaging enabled.
      logic [1:0] avg_sel;     // Averaging count code: 4, 8, 16 or 32.
      logic temp_req;          // Temperature result requested.
      logic ref_wake;          // Reference must power up before converting.
      logic [3:0] chan_first;  // First channel of the scan.
      logic [3:0] chan_last;   // Last channel of the scan.
   } acs_cfg_s;

   // Whole state of the sequencer.
   typedef struct packed {
      logic [3:0] s1;          // First synchroniser stage: cnv, cs, sclk, din.
      logic [3:0] s2;          // Second synchroniser stage.
      logic [3:0] s3;          // Previous second-stage value for edges.
      acs_state_e st;          // Scan sequencer state.
      logic [9:0] cnt;         // Phase timer.
      logic [1:0] mode;        // Clock mode.
      logic eoc_n;             // End of conversion, active low.
      logic adc_on;            // Converter powered.
      logic temp_pend;         // Temperature armed for next rise.
      logic in_temp;           // Current conversion is temperature.
      logic [3:0] chan;        // Multiplexer channel.
      logic [5:0] nconv;       // Conversions accumulated.
      logic [16:0] acc;        // Averaging accumulator.
      logic [15:0][11:0] mem;  // Result FIFO storage.
      logic [3:0] wp;          // FIFO write pointer.
      logic [3:0] rp;          // FIFO read pointer.
      logic [4:0] cnt_f;       // FIFO fill level.
      logic [4:0] idx;         // Bit position in head entry.
      logic [4:0] lim;         // Bit position ending head entry.
      logic dout;              // Serial data out.
      logic [7:0] rx;          // Receive shifter.
      logic [3:0] rxn;         // Received bits in this byte.
      logic [7:0] wr_byte;     // Last written byte.
      logic wr_stb;            // Byte write pulse.
      logic m11;               // Serial-clocked conversion running.
      logic [7:0] m11_n;       // Falling edges since its byte.
      logic [11:0] m11_word;   // Its result.
   } acs_reg_s;
endpackage : acs_pkg

// File: dv/acs_host_model.sv
// Host controller model: drives chip select, serial clock, data in and the convert pin.
module acs_host_model #(
   parameter int HALF_CYC = 4  // Serial clock half period in system clocks.
) (
   input wire logic clk_sys,
   output logic cs_n,
   output logic sclk,
   output logic din,
   output logic convert_start_n,
   input wire logic dout
);
   timeunit 1ns;
   timeprecision 1ns;

   int stall_cyc = 0;  // Extra low time per bit, so the host can be slow.
   logic [199:0] rx;   // Bits seen on data out, first bit highest.

   // Idle pins: deselected, clock parked low, convert pin released.
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      din = 1'b1;
      convert_start_n = 1'b1;
   end

   // ----------------------------------------------------------------
   // Serial frame of n bits; data changes after falls, sampled on rises.
   // ----------------------------------------------------------------
   task automatic xfer(input int n, input logic [199:0] tx);
      rx = '0;
      @(negedge clk_sys);
      cs_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         din = tx[i];
         repeat (HALF_CYC + stall_cyc) @(negedge clk_sys);
         rx[i] = dout;
         sclk = 1'b1;
         repeat (HALF_CYC) @(negedge clk_sys);
         sclk = 1'b0;
      end
      repeat (HALF_CYC) @(negedge clk_sys);
      cs_n = 1'b1;
      // A released data line shows the inverse of its last value.
      din = ~din;
      repeat (8) @(negedge clk_sys);
   endtask : xfer

   // Moves the convert pin to a new level just after a falling clock edge.
   task automatic cnv_drive(input logic v);
      @(negedge clk_sys);
      convert_start_n = v;
   endtask : cnv_drive
endmodule : acs_host_model

// File: dv/acs_conv_seq_test.sv
// Self-checking bench of the conversion sequencer across all four clock modes.
module acs_conv_seq_test;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk_sys;  // System clock, 100 ns period.
   logic rst_b;    // Reset, held low at start.
   logic cs_n, sclk, din, convert_start_n, dout, eoc_n;
   logic mode_load;
   logic [1:0] mode_in;
   logic [1:0] mode;
   acs_pkg::acs_cfg_s cfg;
   logic [11:0] adc_data;
   logic [11:0] temp_data;
   logic adc_on, temp_sel, wr_stb;
   logic [3:0] mux_sel;
   logic [7:0] wr_byte;
   logic [4:0] fifo_level;
   int failures = 0;
   int n_compared = 0;
   int n_wr_stb = 0;  // Write strobes seen since the start.
   logic [11:0] exp_q[$];  // Results expected in the FIFO, oldest first.

   // Free-running system clock.
   always #50 clk_sys = ~clk_sys;

   // Short wake and conversion counts keep the run brief.
   acs_conv_seq #(.WAKE_CYC(2), .CONV_CYC(2)) DUT (
      .clk_sys(clk_sys), .rst_b(rst_b), .convert_start_n(convert_start_n), .cs_n(cs_n),
      .sclk(sclk), .din(din), .dout(dout), .eoc_n(eoc_n), .mode_load(mode_load),
      .mode_in(mode_in), .mode(mode), .cfg(cfg), .adc_data(adc_data), .temp_data(temp_data),
      .adc_on(adc_on), .mux_sel(mux_sel), .temp_sel(temp_sel), .wr_byte(wr_byte), .wr_stb(wr_stb),
      .fifo_level(fifo_level)
   );

   acs_host_model host (
      .clk_sys(clk_sys), .cs_n(cs_n), .sclk(sclk), .din(din),
      .convert_start_n(convert_start_n), .dout(dout)
   );

   // ----------------------------------------------------------------
   // Checking and closing tasks
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : report_and_stop

   // Waits a bounded time for end of conversion; a miss ends the run.
   task automatic wait_eoc(input int limit);
      int k;
      k = 0;
      while (eoc_n !== 1'b0 && k < limit) begin
         @(negedge clk_sys);
         k++;
      end
      if (eoc_n !== 1'b0) begin
         failures++;
         $display("CHECK FAILED eoc_n expected 0 seen %b", eoc_n);
         report_and_stop();
      end
   endtask : wait_eoc

   // Loads a clock mode through the one-cycle load strobe.
   task automatic set_mode(input logic [1:0] m);
      mode_in = m;
      mode_load = 1'b1;
      @(negedge clk_sys);
      mode_load = 1'b0;
      check("mode", 16'(mode), 16'(m));
   endtask : set_mode

   // Reads every expected entry whole and compares it, then the empty level.
   task automatic drain();
      logic [11:0] e;
      while (exp_q.size() > 0) begin
         e = exp_q.pop_front();
         host.xfer(16, 200'h0);
         check("fifo entry", host.rx[15:0], {4'h0, e});
      end
      check("fifo level", 16'(fifo_level), 16'h0000);
   endtask : drain

   // Counts write strobes; each one stands for a single cycle only.
   always @(posedge clk_sys) begin
      if (wr_stb === 1'b1) begin
         n_wr_stb <= n_wr_stb + 1;
      end
   end

   // Watchdog: a hung run counts as a mismatch.
   initial begin
      #6000000;
      failures++;
      $display("CHECK FAILED watchdog expected done seen running");
      report_and_stop();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      rst_b = 1'b0;
      mode_load = 1'b0;
      mode_in = 2'h0;
      cfg = '0;
      adc_data = 12'h000;
      temp_data = 12'h000;
      repeat (8) @(negedge clk_sys);
      rst_b = 1'b1;
      @(negedge clk_sys);
      check("mode", 16'(mode), 16'h0002);
      check("eoc_n", 16'(eoc_n), 16'h0001);
      // Partial write while the FIFO is still empty.
      host.xfer(8, 200'h3c);
      check("wr_byte", 16'(wr_byte), 16'h003c);
      host.xfer(3, 200'h3);
      check("wr_byte", 16'(wr_byte), 16'h007c);
      check("wr_stb count", 16'(n_wr_stb), 16'h0002);
      // Serially started scan with temperature, then partial reads.
      cfg.temp_req = 1'b1;
      cfg.chan_last = 4'h3;
      adc_data = 12'h6d2;
      temp_data = 12'h1f4;
      host.xfer(8, 200'h80);
      wait_eoc(400);
      check("adc_on", 16'(adc_on), 16'h0000);
      check("fifo level", 16'(fifo_level), 16'h0005);
      repeat (20) @(negedge clk_sys);
      check("eoc_n held", 16'(eoc_n), 16'h0000);
      host.xfer(16, 200'h0);
      check("temp first", host.rx[15:0], 16'h01f4);
      check("eoc_n after cs", 16'(eoc_n), 16'h0001);
      host.xfer(4, 200'h0);
      check("lead zeros", 16'(host.rx[3:0]), 16'h0000);
      host.xfer(8, 200'h0);
      check("next bits", 16'(host.rx[7:0]), 16'h006d);
      host.xfer(12, 200'h0);
      check("level after drop", 16'(fifo_level), 16'h0002);
      exp_q = '{12'h6d2, 12'h6d2};
      drain();
      // Convert-pin scan with averaging over eight conversions.
      set_mode(2'h0);
      cfg.temp_req = 1'b0;
      cfg.avg_on = 1'b1;
      cfg.avg_sel = 2'h1;
      cfg.ref_wake = 1'b1;
      cfg.chan_first = 4'h5;
      cfg.chan_last = 4'h5;
      adc_data = 12'h5a1;
      host.cnv_drive(1'b0);
      repeat (3) @(negedge clk_sys);
      host.cnv_drive(1'b1);
      repeat (6) @(negedge clk_sys);
      check("adc_on scan", 16'(adc_on), 16'h0001);
      repeat (600) @(negedge clk_sys);
      check("eoc_n ref wake", 16'(eoc_n), 16'h0001);
      wait_eoc(300);
      check("adc_on off", 16'(adc_on), 16'h0000);
      check("fifo level", 16'(fifo_level), 16'h0001);
      check("mux_sel wrap", 16'(mux_sel), 16'h0005);
      exp_q.push_back(12'h5a1);
      drain();
      // Externally timed acquisitions; one result per four pulses.
      set_mode(2'h1);
      cfg.chan_first = 4'h2;
      cfg.chan_last = 4'h3;
      cfg.avg_sel = 2'h0;
      cfg.ref_wake = 1'b0;
      adc_data = 12'h3c7;
      host.xfer(8, 200'h80);
      check("mux_sel first", 16'(mux_sel), 16'h0002);
      for (int i = 0; i < 4; i++) begin
         host.cnv_drive(1'b0);
         repeat (15) @(negedge clk_sys);
         check("adc_on track", 16'(adc_on), 16'h0001);
         check("eoc_n cleared", 16'(eoc_n), 16'h0001);
         host.cnv_drive(1'b1);
         wait_eoc(100);
         check("adc_on off", 16'(adc_on), 16'h0000);
         check("fifo level", 16'(fifo_level), (i == 3) ? 16'h0001 : 16'h0000);
      end
      check("mux_sel next", 16'(mux_sel), 16'h0003);
      exp_q.push_back(12'h3c7);
      drain();
      // Armed temperature: short pulse, internally timed reference wait.
      cfg.avg_on = 1'b0;
      cfg.temp_req = 1'b1;
      temp_data = 12'h2b8;
      host.xfer(8, 200'h80);
      host.cnv_drive(1'b0);
      repeat (3) @(negedge clk_sys);
      host.cnv_drive(1'b1);
      repeat (600) @(negedge clk_sys);
      check("eoc_n ref wait", 16'(eoc_n), 16'h0001);
      check("temp_sel", 16'(temp_sel), 16'h0001);
      wait_eoc(300);
      exp_q.push_back(12'h2b8);
      drain();
      // Serial-clocked conversions, the first one from a slow host.
      set_mode(2'h3);
      cfg.temp_req = 1'b0;
      adc_data = 12'h9e5;
      host.stall_cyc = 3;
      host.xfer(24, 200'h800000);
      host.stall_cyc = 0;
      check("serial result", host.rx[15:0], 16'h09e5);
      check("no fifo push", 16'(fifo_level), 16'h0000);
      cfg.temp_req = 1'b1;
      temp_data = 12'h0d9;
      host.xfer(8, 200'h80);
      repeat (650) @(negedge clk_sys);
      check("adc_on m11", 16'(adc_on), 16'h0001);
      host.xfer(192, 200'h0);
      check("early window", host.rx[191:176], 16'h0000);
      check("temp result", host.rx[15:0], 16'h00d9);
      report_and_stop();
   end
endmodule : acs_conv_seq_test
